//--- bgc_pkg.sv
// Constants, types and register map of the buck global configuration bank.
package bgc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] BGC_OFS_STARTUP_SHUTDOWN_SLEW     = 8'h33;
  localparam logic [7:0] BGC_OFS_VOLTAGE_RAMP_SLEW         = 8'h34;
  localparam logic [7:0] BGC_OFS_PROTECTION_TRANSIENT_CTRL = 8'h35;
  localparam logic [7:0] BGC_OFS_RESERVED_FIRST            = 8'h36;
  localparam logic [7:0] BGC_OFS_RESERVED_LAST             = 8'hff;

  localparam logic [7:0] BGC_RST_STARTUP_SHUTDOWN_SLEW     = 8'h24;
  localparam logic [7:0] BGC_RST_VOLTAGE_RAMP_SLEW         = 8'h24;
  localparam logic [7:0] BGC_RST_PROTECTION_TRANSIENT_CTRL = 8'h5f;

  // Writable bits of the two slew registers; bits 7 and 3 are reserved.
  localparam logic [7:0] BGC_SLEW_WR_MASK                  = 8'h77;
  localparam logic [7:0] BGC_READ_ZERO                     = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BGC_POS_HIGH_SLEW_LSB  = 4;
  localparam int BGC_POS_LOW_SLEW_LSB   = 0;
  localparam int BGC_POS_ILIM_OFF       = 7;
  localparam int BGC_POS_AZX_EN         = 6;
  localparam int BGC_POS_SHARE_WIDE     = 5;
  localparam int BGC_POS_SHARE_EN       = 4;
  localparam int BGC_POS_BRAKE_EN       = 3;
  localparam int BGC_POS_FALL_MASK      = 2;
  localparam int BGC_POS_RISE_BOOST_EN  = 1;
  localparam int BGC_POS_FALL_BOOST_EN  = 0;

  // ----------------------------------------------------------------------
  // Slew timing
  // ----------------------------------------------------------------------
  localparam int BGC_CLK_PERIOD_NS      = 20;
  localparam int BGC_SLEW_MIN_UV_PER_US = 1250;
  localparam int BGC_VOUT_STEP_UV       = 5000;
  // Reference LSB is the voltage moved in one clock at the slowest rate.
  localparam int BGC_REF_LSB_UV =
    BGC_SLEW_MIN_UV_PER_US * BGC_CLK_PERIOD_NS / 1000;
  localparam logic [7:0] BGC_REF_PER_CODE =
    8'(BGC_VOUT_STEP_UV / BGC_REF_LSB_UV);
  // Per-clock reference steps for 1.25, 2.5, 5, 10, 20, 40 and 60 mV/us.
  localparam logic [5:0] BGC_STEP_1P25 = 6'h01;
  localparam logic [5:0] BGC_STEP_2P5  = 6'h02;
  localparam logic [5:0] BGC_STEP_5    = 6'h04;
  localparam logic [5:0] BGC_STEP_10   = 6'h08;
  localparam logic [5:0] BGC_STEP_20   = 6'h10;
  localparam logic [5:0] BGC_STEP_40   = 6'h20;
  localparam logic [5:0] BGC_STEP_60   = 6'h30;

  localparam logic [2:0]  BGC_SYNC_RST = 3'h0;
  localparam logic [15:0] BGC_REF_RST  = 16'h0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    BGC_OFF,
    BGC_SOFTSTART,
    BGC_REGULATE,
    BGC_RAMP_UP,
    BGC_RAMP_DOWN,
    BGC_SHUTDOWN
  } bgc_ramp_e;

endpackage : bgc_pkg

//--- bgc_slew_if.sv
// Carrier between the bank and one slew code decoder.
`timescale 1ns/10ps
interface bgc_slew_if;
  logic [2:0] code;
  logic [5:0] step;

  modport dec
  (
    input  code,
    output step
  );

  modport user
  (
    output code,
    input  step
  );
endinterface : bgc_slew_if

//--- bgc_slew_step.sv
// Decoder from a three-bit slew code to a per-clock reference step.
`timescale 1ns/10ps
module bgc_slew_step
(
  // Code in, step out
  bgc_slew_if.dec slew
);
  import bgc_pkg::*;

  always_comb
  begin
    unique case (slew.code)
      3'h0:    slew.step = BGC_STEP_1P25;
      3'h1:    slew.step = BGC_STEP_2P5;
      3'h2:    slew.step = BGC_STEP_5;
      3'h3:    slew.step = BGC_STEP_10;
      3'h4:    slew.step = BGC_STEP_20;
      3'h5:    slew.step = BGC_STEP_40;
      // The two top codes both give the fastest rate.
      default: slew.step = BGC_STEP_60;
    endcase
  end

endmodule : bgc_slew_step

//--- bgc_global_cfg.sv
// Buck global configuration bank with slew-limited reference generator.
// How it works
// - 0x33: shutdown slew 6:4, soft-start slew 2:0.
// - 0x34: ramp-down slew 6:4, ramp-up slew 2:0.
// - 0x35 bit 7 set disables current limits.
// - Bit 6 enables adaptive zero crossing, default one.
// - Bit 4 enables sharing, bit 5 selects range.
// - Bit 3 enables body braking on rising transient when bit 1 is set.
// - Bit 2 masks switch-on during falling transient when bit 0 is set.
// - Bits 1,0 enable rising, falling transient boost.
// - Addresses 0x36 to 0xFF are reserved.
// - Forced-mode ramp-down limited to ramp-down slew.
`timescale 1ns/10ps
module bgc_global_cfg
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // Register access port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output var  logic [7:0]  REG_RDATA,
  // Pins from outside the clock domain
  input  wire logic        EN_PIN,
  input  wire logic        FPWM_PIN,
  // Core inputs on this clock
  input  wire logic [7:0]  VOUT_TARGET,
  input  wire logic        RISING_TRANSIENT_EVENT,
  input  wire logic        FALLING_TRANSIENT_EVENT,
  input  wire logic        SWITCH_ON_SIGNAL,
  input  wire logic        PEAK_LIMIT,
  input  wire logic        VALLEY_LIMIT,
  input  wire logic        NEGATIVE_LIMIT,
  // Static configuration outputs
  output var  logic [2:0]  SHUTDOWN_SLEW_CODE,
  output var  logic [2:0]  SOFTSTART_SLEW_CODE,
  output var  logic [2:0]  RAMPDOWN_SLEW_CODE,
  output var  logic [2:0]  RAMPUP_SLEW_CODE,
  output var  logic        CURRENT_LIMIT_DISABLE,
  output var  logic        ADAPTIVE_ZERO_CROSS_ENABLE,
  output var  logic        SHARE_RANGE_WIDE,
  output var  logic        PHASE_SHARE_ENABLE,
  output var  logic        BODY_BRAKE_ENABLE,
  output var  logic        FALLING_TRANSIENT_MASK,
  output var  logic        RISING_TRANSIENT_BOOST_ENABLE,
  output var  logic        FALLING_TRANSIENT_BOOST_ENABLE,
  // Derived control outputs
  output var  logic        BODY_BRAKE_ON,
  output var  logic        SWITCH_ON_GATED,
  output var  logic        LIMIT_TRIP,
  output var  logic        RISING_BOOST_ON,
  output var  logic        FALLING_BOOST_ON,
  output var  logic [15:0] VREF,
  output var  logic        SINK_ENABLE,
  output var  logic        RAMP_BUSY
);
  import bgc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  slew_start_stop;
    logic [7:0]  slew_ramp;
    logic [7:0]  prot_ctrl;
    logic [7:0]  rdata;
    logic [2:0]  en_sync;
    logic [2:0]  fpwm_sync;
    logic        en_lvl;
    logic        fpwm_lvl;
    bgc_ramp_e   ramp;
    logic [15:0] vref;
    logic        sink;
    logic        busy;
    logic        brake_on;
    logic        switch_on;
    logic        limit_trip;
    logic        rise_boost;
    logic        fall_boost;
  } bgc_state_s;

  bgc_state_s state_q;
  bgc_state_s state_d;

  // ----------------------------------------------------------------------
  // Slew decoders, one per field
  // ----------------------------------------------------------------------
  bgc_slew_if sd_if ();
  bgc_slew_if ss_if ();
  bgc_slew_if rd_if ();
  bgc_slew_if ru_if ();

  assign sd_if.code =
    state_q.slew_start_stop[BGC_POS_HIGH_SLEW_LSB +: 3];
  assign ss_if.code =
    state_q.slew_start_stop[BGC_POS_LOW_SLEW_LSB +: 3];
  assign rd_if.code = state_q.slew_ramp[BGC_POS_HIGH_SLEW_LSB +: 3];
  assign ru_if.code = state_q.slew_ramp[BGC_POS_LOW_SLEW_LSB +: 3];

  bgc_slew_step u_sd_step (.slew(sd_if.dec));
  bgc_slew_step u_ss_step (.slew(ss_if.dec));
  bgc_slew_step u_rd_step (.slew(rd_if.dec));
  bgc_slew_step u_ru_step (.slew(ru_if.dec));

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic [15:0] goal;
  logic [5:0]  step;
  logic [16:0] up_sum;
  logic [16:0] dn_dif;
  logic        wr_sss;
  logic        wr_vrs;
  logic        wr_ptc;

  always_comb
  begin
    state_d = state_q;

    // Register writes; reserved addresses take nothing.
    wr_sss = REG_WR && (REG_ADDR == BGC_OFS_STARTUP_SHUTDOWN_SLEW);
    wr_vrs = REG_WR && (REG_ADDR == BGC_OFS_VOLTAGE_RAMP_SLEW);
    wr_ptc = REG_WR && (REG_ADDR == BGC_OFS_PROTECTION_TRANSIENT_CTRL);
    if (wr_sss)
    begin
      state_d.slew_start_stop = REG_WDATA & BGC_SLEW_WR_MASK;
    end
    if (wr_vrs)
    begin
      state_d.slew_ramp = REG_WDATA & BGC_SLEW_WR_MASK;
    end
    if (wr_ptc)
    begin
      state_d.prot_ctrl = REG_WDATA;
    end

    // Read data is registered and holds until the next read.
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        BGC_OFS_STARTUP_SHUTDOWN_SLEW:
          state_d.rdata = state_q.slew_start_stop;
        BGC_OFS_VOLTAGE_RAMP_SLEW:
          state_d.rdata = state_q.slew_ramp;
        BGC_OFS_PROTECTION_TRANSIENT_CTRL:
          state_d.rdata = state_q.prot_ctrl;
        default:
          state_d.rdata = BGC_READ_ZERO;
      endcase
    end

    // Pin synchronisers; a level is taken once stages two and three agree.
    state_d.en_sync   = {state_q.en_sync[1:0], EN_PIN};
    state_d.fpwm_sync = {state_q.fpwm_sync[1:0], FPWM_PIN};
    if (state_q.en_sync[1] == state_q.en_sync[2])
    begin
      state_d.en_lvl = state_q.en_sync[2];
    end
    if (state_q.fpwm_sync[1] == state_q.fpwm_sync[2])
    begin
      state_d.fpwm_lvl = state_q.fpwm_sync[2];
    end

    // Reference sequencing.
    goal = 16'(VOUT_TARGET * BGC_REF_PER_CODE);
    step = (goal < state_q.vref) ? rd_if.step : ru_if.step;
    unique case (state_q.ramp)
      BGC_OFF:
      begin
        goal = BGC_REF_RST;
        if (state_q.en_lvl)
        begin
          state_d.ramp = BGC_SOFTSTART;
        end
      end
      BGC_SOFTSTART:
      begin
        step = ss_if.step;
        if (!state_q.en_lvl)
        begin
          state_d.ramp = BGC_SHUTDOWN;
        end
        else if (state_q.vref == goal)
        begin
          state_d.ramp = BGC_REGULATE;
        end
      end
      BGC_REGULATE:
      begin
        if (!state_q.en_lvl)
        begin
          state_d.ramp = BGC_SHUTDOWN;
        end
        else if (goal > state_q.vref)
        begin
          state_d.ramp = BGC_RAMP_UP;
        end
        else if (goal < state_q.vref)
        begin
          state_d.ramp = BGC_RAMP_DOWN;
        end
      end
      BGC_RAMP_UP, BGC_RAMP_DOWN:
      begin
        step = (goal < state_q.vref) ? rd_if.step : ru_if.step;
        if (!state_q.en_lvl)
        begin
          state_d.ramp = BGC_SHUTDOWN;
        end
        else if (state_q.vref == goal)
        begin
          state_d.ramp = BGC_REGULATE;
        end
        else
        begin
          state_d.ramp = (goal < state_q.vref) ? BGC_RAMP_DOWN
                                               : BGC_RAMP_UP;
        end
      end
      BGC_SHUTDOWN:
      begin
        goal = BGC_REF_RST;
        step = sd_if.step;
        if (state_q.en_lvl)
        begin
          state_d.ramp = BGC_RAMP_UP;
        end
        else if (state_q.vref == BGC_REF_RST)
        begin
          state_d.ramp = BGC_OFF;
        end
      end
      default:
      begin
        state_d.ramp = BGC_OFF;
      end
    endcase

    // One limited step toward the goal, never past it.
    up_sum = {1'b0, state_q.vref} + {11'h000, step};
    dn_dif = {1'b0, state_q.vref} - {11'h000, step};
    if (state_q.vref < goal)
    begin
      state_d.vref = (up_sum[15:0] > goal || up_sum[16]) ? goal
                                                         : up_sum[15:0];
    end
    else if (state_q.vref > goal)
    begin
      // Falling reference moves at the ramp-down, shutdown or soft-start rate.
      state_d.vref = (dn_dif[16] || dn_dif[15:0] < goal) ? goal
                                                         : dn_dif[15:0];
    end

    // In skip mode the stage cannot sink, so only forced mode pulls
    // the output down at the programmed rate.
    state_d.sink = state_q.fpwm_lvl &&
                   ((state_d.ramp == BGC_RAMP_DOWN) ||
                    (state_d.ramp == BGC_SHUTDOWN));
    state_d.busy = (state_d.ramp != BGC_OFF) &&
                   (state_d.ramp != BGC_REGULATE);

    // Gating of core events by the protection and transient controls.
    state_d.limit_trip = !state_q.prot_ctrl[BGC_POS_ILIM_OFF] &&
                         (PEAK_LIMIT || VALLEY_LIMIT ||
                          NEGATIVE_LIMIT);
    state_d.rise_boost = state_q.prot_ctrl[BGC_POS_RISE_BOOST_EN] &&
                         RISING_TRANSIENT_EVENT;
    state_d.fall_boost = state_q.prot_ctrl[BGC_POS_FALL_BOOST_EN] &&
                         FALLING_TRANSIENT_EVENT;
    state_d.brake_on   = state_q.prot_ctrl[BGC_POS_BRAKE_EN] &&
                         state_q.prot_ctrl[BGC_POS_RISE_BOOST_EN] &&
                         RISING_TRANSIENT_EVENT;
    state_d.switch_on  = SWITCH_ON_SIGNAL &&
                         !(state_q.prot_ctrl[BGC_POS_FALL_MASK] &&
                           state_q.prot_ctrl[BGC_POS_FALL_BOOST_EN] &&
                           FALLING_TRANSIENT_EVENT);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_q.slew_start_stop <= BGC_RST_STARTUP_SHUTDOWN_SLEW;
      state_q.slew_ramp       <= BGC_RST_VOLTAGE_RAMP_SLEW;
      state_q.prot_ctrl       <= BGC_RST_PROTECTION_TRANSIENT_CTRL;
      state_q.rdata           <= BGC_READ_ZERO;
      state_q.en_sync         <= BGC_SYNC_RST;
      state_q.fpwm_sync       <= BGC_SYNC_RST;
      state_q.en_lvl          <= 1'b0;
      state_q.fpwm_lvl        <= 1'b0;
      state_q.ramp            <= BGC_OFF;
      state_q.vref            <= BGC_REF_RST;
      state_q.sink            <= 1'b0;
      state_q.busy            <= 1'b0;
      state_q.brake_on        <= 1'b0;
      state_q.switch_on       <= 1'b0;
      state_q.limit_trip      <= 1'b0;
      state_q.rise_boost      <= 1'b0;
      state_q.fall_boost      <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign REG_RDATA           = state_q.rdata;
  assign SHUTDOWN_SLEW_CODE  =
    state_q.slew_start_stop[BGC_POS_HIGH_SLEW_LSB +: 3];
  assign SOFTSTART_SLEW_CODE =
    state_q.slew_start_stop[BGC_POS_LOW_SLEW_LSB +: 3];
  assign RAMPDOWN_SLEW_CODE  =
    state_q.slew_ramp[BGC_POS_HIGH_SLEW_LSB +: 3];
  assign RAMPUP_SLEW_CODE    =
    state_q.slew_ramp[BGC_POS_LOW_SLEW_LSB +: 3];
  assign CURRENT_LIMIT_DISABLE =
    state_q.prot_ctrl[BGC_POS_ILIM_OFF];
  assign ADAPTIVE_ZERO_CROSS_ENABLE =
    state_q.prot_ctrl[BGC_POS_AZX_EN];
  assign SHARE_RANGE_WIDE    =
    state_q.prot_ctrl[BGC_POS_SHARE_WIDE];
  assign PHASE_SHARE_ENABLE  =
    state_q.prot_ctrl[BGC_POS_SHARE_EN];
  assign BODY_BRAKE_ENABLE   =
    state_q.prot_ctrl[BGC_POS_BRAKE_EN];
  assign FALLING_TRANSIENT_MASK =
    state_q.prot_ctrl[BGC_POS_FALL_MASK];
  assign RISING_TRANSIENT_BOOST_ENABLE =
    state_q.prot_ctrl[BGC_POS_RISE_BOOST_EN];
  assign FALLING_TRANSIENT_BOOST_ENABLE =
    state_q.prot_ctrl[BGC_POS_FALL_BOOST_EN];
  assign BODY_BRAKE_ON       = state_q.brake_on;
  assign SWITCH_ON_GATED     = state_q.switch_on;
  assign LIMIT_TRIP          = state_q.limit_trip;
  assign RISING_BOOST_ON     = state_q.rise_boost;
  assign FALLING_BOOST_ON    = state_q.fall_boost;
  assign VREF                = state_q.vref;
  assign SINK_ENABLE         = state_q.sink;
  assign RAMP_BUSY           = state_q.busy;

endmodule : bgc_global_cfg

//--- bgc_global_cfg_chk.sv
// Concurrent checks on the ports of the global configuration bank.
`timescale 1ns/10ps
module bgc_global_cfg_chk
(
  // Clock, reset and register port
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  // Core inputs
  input wire logic        RISING_TRANSIENT_EVENT,
  input wire logic        FALLING_TRANSIENT_EVENT,
  input wire logic        SWITCH_ON_SIGNAL,
  input wire logic        PEAK_LIMIT,
  input wire logic        VALLEY_LIMIT,
  input wire logic        NEGATIVE_LIMIT,
  // Configuration outputs
  input wire logic [2:0]  SHUTDOWN_SLEW_CODE,
  input wire logic [2:0]  SOFTSTART_SLEW_CODE,
  input wire logic [2:0]  RAMPDOWN_SLEW_CODE,
  input wire logic [2:0]  RAMPUP_SLEW_CODE,
  input wire logic        CURRENT_LIMIT_DISABLE,
  input wire logic        ADAPTIVE_ZERO_CROSS_ENABLE,
  input wire logic        SHARE_RANGE_WIDE,
  input wire logic        PHASE_SHARE_ENABLE,
  input wire logic        BODY_BRAKE_ENABLE,
  input wire logic        FALLING_TRANSIENT_MASK,
  input wire logic        RISING_TRANSIENT_BOOST_ENABLE,
  input wire logic        FALLING_TRANSIENT_BOOST_ENABLE,
  // Derived outputs
  input wire logic        BODY_BRAKE_ON,
  input wire logic        SWITCH_ON_GATED,
  input wire logic        LIMIT_TRIP,
  input wire logic [15:0] VREF
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  logic [7:0] ctrl;
  logic       brake_c;
  logic       sw_c;
  logic       lim_c;
  assign ctrl = {CURRENT_LIMIT_DISABLE, ADAPTIVE_ZERO_CROSS_ENABLE,
                 SHARE_RANGE_WIDE, PHASE_SHARE_ENABLE, BODY_BRAKE_ENABLE,
                 FALLING_TRANSIENT_MASK, RISING_TRANSIENT_BOOST_ENABLE,
                 FALLING_TRANSIENT_BOOST_ENABLE};
  assign brake_c = RISING_TRANSIENT_EVENT & RISING_TRANSIENT_BOOST_ENABLE
                   & BODY_BRAKE_ENABLE;
  assign sw_c = SWITCH_ON_SIGNAL & ~(FALLING_TRANSIENT_MASK
                & FALLING_TRANSIENT_BOOST_ENABLE & FALLING_TRANSIENT_EVENT);
  assign lim_c = ~CURRENT_LIMIT_DISABLE
                 & (PEAK_LIMIT | VALLEY_LIMIT | NEGATIVE_LIMIT);

  a_reset_defaults: assert property ($past(SYS_RST) |->
    {SHUTDOWN_SLEW_CODE, SOFTSTART_SLEW_CODE, RAMPDOWN_SLEW_CODE,
     RAMPUP_SLEW_CODE, ctrl} == {3'h2, 3'h4, 3'h2, 3'h4, 8'h5f})
    else $error("Defaults wrong after reset");
  a_slew_one_write: assert property (
    REG_WR && REG_ADDR == 8'h33 |=> {1'b0, SHUTDOWN_SLEW_CODE, 1'b0,
    SOFTSTART_SLEW_CODE} == ($past(REG_WDATA) & 8'h77))
    else $error("Startup slew codes do not follow write");
  a_slew_two_write: assert property (
    REG_WR && REG_ADDR == 8'h34 |=> {1'b0, RAMPDOWN_SLEW_CODE, 1'b0,
    RAMPUP_SLEW_CODE} == ($past(REG_WDATA) & 8'h77))
    else $error("Ramp slew codes do not follow write");
  a_ctrl_write: assert property (
    REG_WR && REG_ADDR == 8'h35 |=> ctrl == $past(REG_WDATA))
    else $error("Control bits do not follow write");
  a_rsvd_read_zero: assert property (
    REG_RD && REG_ADDR >= 8'h36 |=> REG_RDATA == 8'h00)
    else $error("Reserved address read not zero");
  a_rsvd_bits_zero: assert property (
    REG_RD && REG_ADDR inside {8'h33, 8'h34} |=> (REG_RDATA & 8'h88) == 0)
    else $error("Reserved slew bits read not zero");
  a_ctrl_readback: assert property (
    REG_RD && REG_ADDR == 8'h35 |=> REG_RDATA == $past(ctrl))
    else $error("Control readback differs from outputs");
  a_brake_gate: assert property (
    !$past(SYS_RST) |-> BODY_BRAKE_ON == $past(brake_c))
    else $error("Body brake output wrong");
  a_switch_gate: assert property (
    !$past(SYS_RST) |-> SWITCH_ON_GATED == $past(sw_c))
    else $error("Switch-on gating wrong");
  a_limit_gate: assert property (
    !$past(SYS_RST) |-> LIMIT_TRIP == $past(lim_c))
    else $error("Limit trip wrong");
  a_vref_fall_step: assert property (
    !$past(SYS_RST) && VREF < $past(VREF) |-> $past(VREF) - VREF <= 16'd48)
    else $error("Reference falls faster than fastest slew");

  cover property (REG_WR && REG_ADDR == 8'h35);
  cover property (REG_RD && REG_ADDR >= 8'h36);
  cover property (BODY_BRAKE_ON && LIMIT_TRIP);
endmodule : bgc_global_cfg_chk

bind bgc_global_cfg bgc_global_cfg_chk bgc_global_cfg_chk_i
(
  .CLOCK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
  .RISING_TRANSIENT_EVENT, .FALLING_TRANSIENT_EVENT, .SWITCH_ON_SIGNAL,
  .PEAK_LIMIT, .VALLEY_LIMIT, .NEGATIVE_LIMIT, .SHUTDOWN_SLEW_CODE,
  .SOFTSTART_SLEW_CODE, .RAMPDOWN_SLEW_CODE, .RAMPUP_SLEW_CODE,
  .CURRENT_LIMIT_DISABLE, .ADAPTIVE_ZERO_CROSS_ENABLE, .SHARE_RANGE_WIDE,
  .PHASE_SHARE_ENABLE, .BODY_BRAKE_ENABLE, .FALLING_TRANSIENT_MASK,
  .RISING_TRANSIENT_BOOST_ENABLE, .FALLING_TRANSIENT_BOOST_ENABLE,
  .BODY_BRAKE_ON, .SWITCH_ON_GATED, .LIMIT_TRIP, .VREF
);

//--- bgc_host_model.sv
// Host side model that issues register reads and writes.
`timescale 1ns/10ps
module bgc_host_model
(
  // Clock
  input  wire logic       clk,
  // Register access port
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // Each request stands across exactly one rising edge.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    // Released data shows the inverse, so a stale value never looks valid.
    reg_wdata = ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    data     = reg_rdata;
  endtask : rd
endmodule : bgc_host_model

//--- bgc_global_cfg_tb_top.sv
// Self-checking testbench of the global configuration bank.
`timescale 1ns/10ps
module bgc_global_cfg_tb_top;
  import bgc_pkg::*;

  logic        CLOCK, SYS_RST, REG_WR, REG_RD, EN_PIN, FPWM_PIN;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, VOUT_TARGET;
  logic        RISING_TRANSIENT_EVENT, FALLING_TRANSIENT_EVENT;
  logic        SWITCH_ON_SIGNAL, PEAK_LIMIT, VALLEY_LIMIT, NEGATIVE_LIMIT;
  logic [2:0]  SHUTDOWN_SLEW_CODE, SOFTSTART_SLEW_CODE;
  logic [2:0]  RAMPDOWN_SLEW_CODE, RAMPUP_SLEW_CODE;
  logic        CURRENT_LIMIT_DISABLE, ADAPTIVE_ZERO_CROSS_ENABLE;
  logic        SHARE_RANGE_WIDE, PHASE_SHARE_ENABLE, BODY_BRAKE_ENABLE;
  logic        FALLING_TRANSIENT_MASK, RISING_TRANSIENT_BOOST_ENABLE;
  logic        FALLING_TRANSIENT_BOOST_ENABLE, BODY_BRAKE_ON;
  logic        SWITCH_ON_GATED, LIMIT_TRIP, RISING_BOOST_ON;
  logic        FALLING_BOOST_ON, SINK_ENABLE, RAMP_BUSY;
  logic [15:0] VREF;
  logic [7:0]  ctrl;
  logic [11:0] slews;
  int          miscompares = 0;
  int          checks = 0;

  // Gating table: control value and expected {brake, rise, fall, sw, lim}.
  localparam logic [7:0] GATE_CFG [5] = '{8'h5f, 8'h80, 8'h0a, 8'h05, 8'h01};
  localparam logic [4:0] GATE_EXP [5] = '{5'h1d, 5'h02, 5'h1b, 5'h05, 5'h07};
  // Ramp-down code 2 is 5 mV/us: 0.1 mV per 20 ns clock, 4 steps of 25 uV.
  localparam logic [15:0] RD_STEP = 16'h0004;

  assign ctrl = {CURRENT_LIMIT_DISABLE, ADAPTIVE_ZERO_CROSS_ENABLE,
                 SHARE_RANGE_WIDE, PHASE_SHARE_ENABLE, BODY_BRAKE_ENABLE,
                 FALLING_TRANSIENT_MASK, RISING_TRANSIENT_BOOST_ENABLE,
                 FALLING_TRANSIENT_BOOST_ENABLE};
  assign slews = {SHUTDOWN_SLEW_CODE, SOFTSTART_SLEW_CODE,
                  RAMPDOWN_SLEW_CODE, RAMPUP_SLEW_CODE};

  bgc_host_model bgc_host_model_i
  (
    .clk(CLOCK), .reg_addr(REG_ADDR), .reg_wr(REG_WR),
    .reg_wdata(REG_WDATA), .reg_rd(REG_RD), .reg_rdata(REG_RDATA)
  );

  bgc_global_cfg bgc_global_cfg_i
  (
    .CLOCK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
    .EN_PIN, .FPWM_PIN, .VOUT_TARGET, .RISING_TRANSIENT_EVENT,
    .FALLING_TRANSIENT_EVENT, .SWITCH_ON_SIGNAL, .PEAK_LIMIT, .VALLEY_LIMIT,
    .NEGATIVE_LIMIT, .SHUTDOWN_SLEW_CODE, .SOFTSTART_SLEW_CODE,
    .RAMPDOWN_SLEW_CODE, .RAMPUP_SLEW_CODE, .CURRENT_LIMIT_DISABLE,
    .ADAPTIVE_ZERO_CROSS_ENABLE, .SHARE_RANGE_WIDE, .PHASE_SHARE_ENABLE,
    .BODY_BRAKE_ENABLE, .FALLING_TRANSIENT_MASK,
    .RISING_TRANSIENT_BOOST_ENABLE, .FALLING_TRANSIENT_BOOST_ENABLE,
    .BODY_BRAKE_ON, .SWITCH_ON_GATED, .LIMIT_TRIP, .RISING_BOOST_ON,
    .FALLING_BOOST_ON, .VREF, .SINK_ENABLE, .RAMP_BUSY
  );

  always #10 CLOCK = ~CLOCK;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic reset_and_check;
    logic [7:0] d;
    SYS_RST = 1'b1;
    repeat (3) @(negedge CLOCK);
    SYS_RST = 1'b0;
    bgc_host_model_i.rd(8'h33, d);
    check(d, BGC_RST_STARTUP_SHUTDOWN_SLEW);
    bgc_host_model_i.rd(8'h34, d);
    check(d, BGC_RST_VOLTAGE_RAMP_SLEW);
    bgc_host_model_i.rd(8'h35, d);
    check(d, BGC_RST_PROTECTION_TRANSIENT_CTRL);
    check(slews, {3'h2, 3'h4, 3'h2, 3'h4});
    check(ctrl, 8'h5f);
  endtask : reset_and_check

  // Bounded wait for the reference to settle.
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (8) @(negedge CLOCK);
    while (RAMP_BUSY !== 1'b0 && n < 2000)
    begin
      @(negedge CLOCK);
      n++;
    end
  endtask : wait_idle

  initial
  begin
    logic [7:0]  d, w;
    logic [7:0]  rsv [3];
    logic [15:0] prev;
    int          n;
    rsv = '{8'h36, 8'h80, 8'hff};
    {CLOCK, SYS_RST, EN_PIN, FPWM_PIN, SWITCH_ON_SIGNAL} = '0;
    {RISING_TRANSIENT_EVENT, FALLING_TRANSIENT_EVENT} = '0;
    {PEAK_LIMIT, VALLEY_LIMIT, NEGATIVE_LIMIT} = '0;
    VOUT_TARGET = 8'h00;
    reset_and_check();
    for (int c = 0; c < 8; c++)
    begin
      w = {1'b1, 3'(c), 1'b1, 3'(7 - c)};
      bgc_host_model_i.wr(8'h33, w);
      bgc_host_model_i.wr(8'h34, ~w);
      bgc_host_model_i.rd(8'h33, d);
      check(d, w & 8'h77);
      bgc_host_model_i.rd(8'h34, d);
      check(d, ~w & 8'h77);
      check(slews, {3'(c), 3'(7 - c), 3'(7 - c), 3'(c)});
    end
    for (int i = 0; i < 8; i++)
    begin
      bgc_host_model_i.wr(8'h35, 8'h01 << i);
      bgc_host_model_i.rd(8'h35, d);
      check(d, 8'h01 << i);
      check(ctrl, 8'h01 << i);
    end
    foreach (rsv[k])
    begin
      bgc_host_model_i.wr(rsv[k], 8'hff);
      bgc_host_model_i.rd(rsv[k], d);
      check(d, 8'h00);
    end
    check(ctrl, 8'h80);
    check(slews, {3'h7, 3'h0, 3'h0, 3'h7});
    {RISING_TRANSIENT_EVENT, FALLING_TRANSIENT_EVENT} = 2'b11;
    SWITCH_ON_SIGNAL = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      bgc_host_model_i.wr(8'h35, GATE_CFG[k]);
      {PEAK_LIMIT, VALLEY_LIMIT, NEGATIVE_LIMIT} = 3'b001 << (k % 3);
      @(negedge CLOCK);
      check({BODY_BRAKE_ON, RISING_BOOST_ON, FALLING_BOOST_ON,
             SWITCH_ON_GATED, LIMIT_TRIP},
            GATE_EXP[k]);
    end
    {RISING_TRANSIENT_EVENT, FALLING_TRANSIENT_EVENT} = 2'b00;
    {SWITCH_ON_SIGNAL, PEAK_LIMIT, VALLEY_LIMIT, NEGATIVE_LIMIT} = '0;
    reset_and_check();
    VOUT_TARGET = 8'd10;
    EN_PIN = 1'b1;
    wait_idle();
    check(VREF, 16'd2000);
    FPWM_PIN = 1'b1;
    repeat (4) @(negedge CLOCK);
    VOUT_TARGET = 8'd5;
    n = 0;
    while (VREF >= 16'd2000 && n < 50)
    begin
      @(negedge CLOCK);
      n++;
    end
    check(VREF, 16'd1996);
    prev = VREF;
    repeat (8)
    begin
      @(negedge CLOCK);
      check(prev - VREF, RD_STEP);
      prev = VREF;
    end
    check(SINK_ENABLE, 1'b1);
    wait_idle();
    check(VREF, 16'd1000);
    EN_PIN = 1'b0;
    wait_idle();
    check(VREF, 16'd0);
    final_report();
  end

  // The tests take about 800 cycles; this limit leaves wide margin.
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    miscompares++;
    final_report();
  end
endmodule : bgc_global_cfg_tb_top
